//--- design/swk_pkg.sv
// Summary of operation
// - sense field picks low level, any change, falling or rising edge of the pin.
// - pin request only with global enable in status word and pin mask both set.
// - pin is synchronised before edge detection; pulses over one clock are caught.
// - level mode keeps the request asserted for as long as the pin is low.
// - sleep only on sleep instruction with sleep_allow set; depth bit picks mode.
// - idle halts only the cpu; interrupts and watchdog still wake it.
// - small variant resumes at once after an idle wake.
// - power-down stops main oscillator; pin logic and watchdog keep running.
// - power-down wakes only on resets, low level or pin change; never edges.
// - enabled interrupt wakes, service runs, then code after sleep continues.
// - large variant halts the cpu four cycles after an interrupt wake.
// - small variant runs two instructions after power-down pin-change wake before service.
// - register contents stay unchanged across every sleep state.
// - reset during sleep wakes and restarts from the reset vector.
// - both variants wake once level held two watchdog ticks or whole wake period.
// - wake condition lost early still wakes but without the interrupt routine.
// - power-down wake delay follows the clock source fuse setting.
// - watchdog oscillator times watchdog and time-out even with internal rc clock.
// - pin flag sets on trigger, clears on vector or written one; zero in level mode.
// - depth bit zero selects idle, one selects power-down for the sleep instruction.
package swk_pkg;
  // -----------------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------------
  localparam logic [11:0] OFS_MCU_CONTROL = 12'h000;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h004;
  localparam logic [11:0] OFS_IRQ_FLAG    = 12'h008;
  localparam logic [11:0] OFS_OSC_TRIM    = 12'h00c;
  localparam logic [11:0] OFS_SLEEP_STAT  = 12'h010;
  localparam int          BIT_SLEEP_ALLOW = 5;
  localparam int          BIT_SLEEP_DEPTH = 4;
  localparam int          BIT_SENSE_HI    = 1;
  localparam int          BIT_SENSE_LO    = 0;
  localparam int          BIT_EXT_MASK    = 6;
  localparam int          BIT_EXT_FLAG    = 6;
  localparam int          BIT_NO_IRQ_WAKE = 7;
  localparam logic [7:0]  MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0]  MCU_CONTROL_WM  = 8'h33;
  localparam logic        IRQ_MASK_RST    = 1'b0;
  localparam logic [7:0]  OSC_TRIM_RST    = 8'h00;
  // -----------------------------------------------------------------------
  // sense codes
  // -----------------------------------------------------------------------
  localparam logic [1:0]  SENSE_LOW  = 2'h0;
  localparam logic [1:0]  SENSE_ANY  = 2'h1;
  localparam logic [1:0]  SENSE_FALL = 2'h2;
  localparam logic [1:0]  SENSE_RISE = 2'h3;
  // -----------------------------------------------------------------------
  // timing counts
  // -----------------------------------------------------------------------
  localparam logic [7:0]  PD_HOLD_TICKS = 8'h02;
  localparam logic [2:0]  HALT_CYCLES   = 3'h4;
  localparam logic [1:0]  DEFER_INSTR   = 2'h2;
  // wake period in watchdog ticks per fuse code; plain defaults
  localparam logic [7:0]  WAKE_TICKS_0  = 8'h01;
  localparam logic [7:0]  WAKE_TICKS_1  = 8'h04;
  localparam logic [7:0]  WAKE_TICKS_2  = 8'h10;
  localparam logic [7:0]  WAKE_TICKS_3  = 8'h40;
  // -----------------------------------------------------------------------
  // states
  // -----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RUN   = 6'h01,
    ST_IDLE  = 6'h02,
    ST_PDOWN = 6'h04,
    ST_WAKE  = 6'h08,
    ST_HALT  = 6'h10,
    ST_DEFER = 6'h20
  } swk_state_type;

  function automatic logic [7:0] wake_ticks(input logic [1:0] fuses);
    logic [7:0] t;
    t = WAKE_TICKS_0;
    if (fuses == 2'h1) t = WAKE_TICKS_1;
    else if (fuses == 2'h2) t = WAKE_TICKS_2;
    else if (fuses == 2'h3) t = WAKE_TICKS_3;
    return t;
  endfunction
endpackage

//--- design/swk_sync.sv
`timescale 1ns/1ps
module swk_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } swk_sync_type;

  swk_sync_type st_reg;
  swk_sync_type st_next;

  // first stage feeds only the second stage
  always_comb
  begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sync_out = st_reg.s2;
endmodule

//--- design/swk_top.sv
`timescale 1ns/1ps
module swk_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  input  wire logic        wdt_osc_clk,
  input  wire logic [1:0]  clock_source_fuses,
  input  wire logic        status_word_gie,
  input  wire logic        sleep_exec,
  input  wire logic        instr_done,
  input  wire logic        ext_irq_ack,
  input  wire logic        pin_change_req,
  input  wire logic        other_irq_req,
  input  wire logic        wdt_reset_req,
  input  wire logic        ext_reset_req,
  output logic             ext_irq_req,
  output logic             cpu_halt,
  output logic             main_osc_stop,
  output logic             pc_flag_hold,
  output logic             restart_reset_vector,
  output logic      [7:0]  osc_trim
);
  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    swk_pkg::swk_state_type state;
    logic [7:0]             mcu;
    logic                   ext_mask;
    logic                   ext_flag;
    logic [7:0]             trim;
    logic                   pin_d;
    logic                   wdt_d;
    logic [7:0]             tick_cnt;
    logic [2:0]             halt_cnt;
    logic [1:0]             instr_cnt;
    logic                   pc_wake;
    logic                   no_irq_wake;
    logic                   restart;
    logic [31:0]            rdata;
  } swk_regs_type;

  swk_regs_type st_reg;
  swk_regs_type st_next;

  logic [1:0] sync_out;
  logic       pin_sync;
  logic       wdt_sync;

  // -----------------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------------
  swk_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({wdt_osc_clk, ext_irq_pin}),
    .sync_out (sync_out)
  );

  assign pin_sync = sync_out[0];
  assign wdt_sync = sync_out[1];

  // -----------------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------------
  function automatic logic [4:0] reg_sel(input logic [11:0] addr);
    logic [4:0] sel;
    sel = 5'h00;
    if (addr == swk_pkg::OFS_MCU_CONTROL) sel = 5'h01;
    else if (addr == swk_pkg::OFS_IRQ_MASK) sel = 5'h02;
    else if (addr == swk_pkg::OFS_IRQ_FLAG) sel = 5'h04;
    else if (addr == swk_pkg::OFS_OSC_TRIM) sel = 5'h08;
    else if (addr == swk_pkg::OFS_SLEEP_STAT) sel = 5'h10;
    return sel;
  endfunction

  logic [1:0] sense;
  logic       level_mode;
  logic       rise;
  logic       fall;
  logic       edge_evt;
  logic       pend;
  logic       level_pend;
  logic       pd_cond;
  logic       any_reset;
  logic       wdt_tick;
  logic [7:0] wake_len;
  logic [7:0] hold_len;
  logic [4:0] sel;
  logic       wr;
  logic       flag_clr;
  logic       in_run;
  logic       sleeping;

  assign sense      = st_reg.mcu[swk_pkg::BIT_SENSE_HI:swk_pkg::BIT_SENSE_LO];
  assign level_mode = (sense == swk_pkg::SENSE_LOW);
  assign rise       = pin_sync & ~st_reg.pin_d;
  assign fall       = ~pin_sync & st_reg.pin_d;
  assign sel        = reg_sel(paddr);
  assign wr         = psel & penable & pwrite;
  assign flag_clr   = ext_irq_ack | (wr & sel[2] & pwdata[swk_pkg::BIT_EXT_FLAG]);
  assign any_reset  = ext_reset_req | wdt_reset_req;
  // watchdog oscillator keeps timing wake periods whatever the system clock
  assign wdt_tick   = wdt_sync & ~st_reg.wdt_d;
  assign wake_len   = swk_pkg::wake_ticks(clock_source_fuses);
  assign hold_len   = (wake_len < swk_pkg::PD_HOLD_TICKS) ? wake_len
                                                         : swk_pkg::PD_HOLD_TICKS;
  assign in_run     = (st_reg.state == swk_pkg::ST_RUN);
  assign sleeping   = (st_reg.state == swk_pkg::ST_IDLE) ||
                      (st_reg.state == swk_pkg::ST_PDOWN) ||
                      (st_reg.state == swk_pkg::ST_WAKE);

  always_comb
  begin
    edge_evt = 1'b0;
    case (sense)
      swk_pkg::SENSE_ANY:  edge_evt = rise | fall;
      swk_pkg::SENSE_FALL: edge_evt = fall;
      swk_pkg::SENSE_RISE: edge_evt = rise;
      default:             edge_evt = 1'b0;
    endcase
  end

  // level request is a plain function of the pin, so it lasts while low
  assign level_pend = level_mode & ~pin_sync & st_reg.ext_mask & status_word_gie;
  assign pend       = st_reg.ext_mask & status_word_gie &
                      (level_mode ? ~pin_sync : st_reg.ext_flag);
  // edge requests are deliberately absent from the power-down wake term
  assign pd_cond    = level_pend | pin_change_req;

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] cnt_inc;
    logic       lost;
    cnt_inc = 8'h00;
    lost    = 1'b0;
    st_next         = st_reg;
    st_next.restart = 1'b0;
    st_next.pin_d   = pin_sync;
    st_next.wdt_d   = wdt_sync;
    cnt_inc         = st_reg.tick_cnt + {7'h00, wdt_tick};

    // set wins over clear; level mode holds the flag at zero
    if (level_mode)
      st_next.ext_flag = 1'b0;
    else if (edge_evt)
      st_next.ext_flag = 1'b1;
    else if (flag_clr)
      st_next.ext_flag = 1'b0;

    // only bus writes touch the registers; sleep states leave them alone
    if (wr && sel[0])
      st_next.mcu = pwdata[7:0] & swk_pkg::MCU_CONTROL_WM;
    if (wr && sel[1])
      st_next.ext_mask = pwdata[swk_pkg::BIT_EXT_MASK];
    if (wr && sel[3])
      st_next.trim = pwdata[7:0];

    // read data is latched in the setup phase so it comes from a flop
    if (psel && !penable && !pwrite)
    begin
      st_next.rdata = 32'h0000_0000;
      if (sel[0])
        st_next.rdata[7:0] = st_reg.mcu;
      else if (sel[1])
        st_next.rdata[swk_pkg::BIT_EXT_MASK] = st_reg.ext_mask;
      else if (sel[2])
        st_next.rdata[swk_pkg::BIT_EXT_FLAG] = st_reg.ext_flag;
      else if (sel[3])
        st_next.rdata[7:0] = st_reg.trim;
      else if (sel[4])
        st_next.rdata[7:0] = {st_reg.no_irq_wake, 1'b0, st_reg.state};
    end

    case (st_reg.state)
      swk_pkg::ST_RUN:
      begin
        if (sleep_exec && st_reg.mcu[swk_pkg::BIT_SLEEP_ALLOW])
        begin
          st_next.state       = st_reg.mcu[swk_pkg::BIT_SLEEP_DEPTH] ?
                                swk_pkg::ST_PDOWN : swk_pkg::ST_IDLE;
          st_next.tick_cnt    = 8'h00;
          st_next.no_irq_wake = 1'b0;
          st_next.pc_wake     = 1'b0;
        end
      end
      swk_pkg::ST_IDLE:
      begin
        if (any_reset)
        begin
          st_next.state   = swk_pkg::ST_RUN;
          st_next.restart = 1'b1;
        end
        else if (pend || pin_change_req || other_irq_req)
        begin
          st_next.halt_cnt = 3'h0;
          st_next.state    = LARGE_VARIANT ? swk_pkg::ST_HALT : swk_pkg::ST_RUN;
        end
      end
      swk_pkg::ST_PDOWN:
      begin
        if (any_reset)
        begin
          st_next.state   = swk_pkg::ST_RUN;
          st_next.restart = 1'b1;
        end
        else if (pd_cond)
        begin
          st_next.tick_cnt = cnt_inc;
          if (cnt_inc >= hold_len)
          begin
            st_next.state   = swk_pkg::ST_WAKE;
            st_next.pc_wake = pin_change_req;
          end
        end
        else
          st_next.tick_cnt = 8'h00;
      end
      swk_pkg::ST_WAKE:
      begin
        lost = st_reg.no_irq_wake | ~pd_cond;
        st_next.no_irq_wake = lost;
        st_next.tick_cnt    = cnt_inc;
        if (any_reset)
        begin
          st_next.state   = swk_pkg::ST_RUN;
          st_next.restart = 1'b1;
        end
        else if (cnt_inc >= wake_len)
        begin
          st_next.halt_cnt  = 3'h0;
          st_next.instr_cnt = 2'h0;
          if (LARGE_VARIANT)
            st_next.state = swk_pkg::ST_HALT;
          else if (st_reg.pc_wake && !lost)
            st_next.state = swk_pkg::ST_DEFER;
          else
            st_next.state = swk_pkg::ST_RUN;
        end
      end
      swk_pkg::ST_HALT:
      begin
        st_next.halt_cnt = st_reg.halt_cnt + 3'h1;
        if (st_reg.halt_cnt == swk_pkg::HALT_CYCLES - 3'h1)
          st_next.state = swk_pkg::ST_RUN;
      end
      swk_pkg::ST_DEFER:
      begin
        if (instr_done)
        begin
          st_next.instr_cnt = st_reg.instr_cnt + 2'h1;
          if (st_reg.instr_cnt == swk_pkg::DEFER_INSTR - 2'h1)
            st_next.state = swk_pkg::ST_RUN;
        end
      end
      default:
        st_next.state = swk_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg          <= '0;
      st_reg.state    <= swk_pkg::ST_RUN;
      st_reg.mcu      <= swk_pkg::MCU_CONTROL_RST;
      st_reg.ext_mask <= swk_pkg::IRQ_MASK_RST;
      st_reg.trim     <= swk_pkg::OSC_TRIM_RST;
    end
    else
      st_reg <= st_next;
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign prdata               = st_reg.rdata;
  assign pready               = 1'b1;
  assign pslverr              = psel & penable & (sel == 5'h00);
  // request only in run, so after wake it is served and code after sleep resumes
  assign ext_irq_req          = pend & in_run;
  assign cpu_halt             = sleeping | (st_reg.state == swk_pkg::ST_HALT);
  // main clock is modelled as stopped only; pclk itself keeps running here
  assign main_osc_stop        = (st_reg.state == swk_pkg::ST_PDOWN) ||
                                (st_reg.state == swk_pkg::ST_WAKE);
  assign pc_flag_hold         = (st_reg.state == swk_pkg::ST_DEFER);
  assign restart_reset_vector = st_reg.restart;
  assign osc_trim             = st_reg.trim;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fall_edge_flag: assert property (
    (sense == swk_pkg::SENSE_FALL) && $fell(pin_sync) && !level_mode |=> st_reg.ext_flag)
    else $error("falling edge did not set flag");
  chk_rise_no_flag: assert property (
    (sense == swk_pkg::SENSE_FALL) && $rose(pin_sync) && !st_reg.ext_flag && !$past(fall)
    ##0 $stable(sense) |=> !st_reg.ext_flag)
    else $error("rising edge set flag in falling mode");
  chk_irq_gating: assert property (
    ext_irq_req |-> status_word_gie && st_reg.ext_mask)
    else $error("request without both enables");
  chk_level_flag_zero: assert property (
    level_mode && $past(level_mode) |-> !st_reg.ext_flag)
    else $error("flag set in level mode");
  chk_sleep_gate: assert property (
    in_run && sleep_exec && !st_reg.mcu[swk_pkg::BIT_SLEEP_ALLOW] |=> in_run)
    else $error("slept without sleep_allow");
  chk_pd_entry: assert property (
    in_run && sleep_exec && st_reg.mcu[swk_pkg::BIT_SLEEP_ALLOW] &&
    st_reg.mcu[swk_pkg::BIT_SLEEP_DEPTH] |=> main_osc_stop && cpu_halt)
    else $error("power-down not entered");
  chk_pd_edge_ignored: assert property (
    (st_reg.state == swk_pkg::ST_PDOWN) && !pd_cond && !any_reset |=>
    (st_reg.state == swk_pkg::ST_PDOWN))
    else $error("power-down left without wake source");
  chk_halt_four: assert property (
    $rose(st_reg.state == swk_pkg::ST_HALT) |->
    (st_reg.state == swk_pkg::ST_HALT)[*4] ##1 in_run)
    else $error("halt not four cycles");
  chk_sleep_reset: assert property (
    sleeping && any_reset |=> restart_reset_vector && in_run ##1 !restart_reset_vector)
    else $error("reset in sleep did not restart");

  cov_idle_wake: cover property ((st_reg.state == swk_pkg::ST_IDLE) ##1 in_run);
  cov_pd_wake: cover property ((st_reg.state == swk_pkg::ST_WAKE) ##1 !main_osc_stop);
  cov_lost_wake: cover property ($rose(st_reg.no_irq_wake));
  cov_defer: cover property ($fell(pc_flag_hold));
endmodule

//--- verification/swk_pin_model.sv
`timescale 1ns/1ps
module swk_pin_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want_low,
  input  wire logic level_mode,
  input  wire logic instr_done,
  output logic      ext_irq_pin
);
  // ---------------------------------------------------------------
  // external pin driver
  // ---------------------------------------------------------------
  logic done_seen;

  // idle level is high; in level mode a low is not released before an
  // instruction has finished, since the request may be lost otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_irq_pin <= 1'b1;
      done_seen   <= 1'b0;
    end
    else if (want_low)
    begin
      ext_irq_pin <= 1'b0;
      done_seen   <= done_seen | (~ext_irq_pin & instr_done);
    end
    else if (!level_mode || done_seen)
    begin
      ext_irq_pin <= 1'b1;
      done_seen   <= 1'b0;
    end
  end
endmodule

//--- verification/swk_top_tb_top.sv
`timescale 1ns/1ps
module swk_top_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr, ext_irq_pin, wdt_osc_clk = 1'b0;
  logic [1:0]  clock_source_fuses = 2'h0;
  logic        status_word_gie = 1'b0, sleep_exec = 1'b0, instr_done = 1'b0;
  logic        ext_irq_ack = 1'b0, pin_change_req = 1'b0, other_irq_req = 1'b0;
  logic        ext_reset_req = 1'b0, want_low = 1'b0, level_mode = 1'b0, rv_seen = 1'b0;
  logic        wdt_reset_req = 1'b0;
  logic        ext_irq_req, cpu_halt, main_osc_stop, pc_flag_hold, restart_reset_vector;
  logic        s_ext_irq_req, s_cpu_halt, s_main_osc_stop, s_pc_flag_hold, s_restart;
  logic [7:0]  osc_trim, s_osc_trim;
  int          errors = 0, check_count = 0, idc = 0, nl, ns;

  // ---------------------------------------------------------------
  // clocks, devices and monitors
  // ---------------------------------------------------------------
  always #50 pclk = ~pclk;
  // watchdog ticks every 690 ns; its rising edges never meet a pclk rising edge
  always #345 wdt_osc_clk = ~wdt_osc_clk;
  always @(posedge pclk) instr_done <= ~instr_done;
  always @(posedge pclk) if (restart_reset_vector) rv_seen <= 1'b1;
  always @(posedge pclk) if (s_pc_flag_hold && instr_done) idc <= idc + 1;

  swk_top #(.LARGE_VARIANT(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .wdt_osc_clk(wdt_osc_clk), .clock_source_fuses(clock_source_fuses),
    .status_word_gie(status_word_gie), .sleep_exec(sleep_exec), .instr_done(instr_done),
    .ext_irq_ack(ext_irq_ack), .pin_change_req(pin_change_req), .other_irq_req(other_irq_req),
    .wdt_reset_req(wdt_reset_req), .ext_reset_req(ext_reset_req), .ext_irq_req(ext_irq_req),
    .cpu_halt(cpu_halt), .main_osc_stop(main_osc_stop), .pc_flag_hold(pc_flag_hold),
    .restart_reset_vector(restart_reset_vector), .osc_trim(osc_trim));

  // small variant sees the same traffic; only its sleep outputs are judged
  swk_top #(.LARGE_VARIANT(1'b0)) uut_small (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .ext_irq_pin(ext_irq_pin), .wdt_osc_clk(wdt_osc_clk), .clock_source_fuses(clock_source_fuses),
    .status_word_gie(status_word_gie), .sleep_exec(sleep_exec), .instr_done(instr_done),
    .ext_irq_ack(ext_irq_ack), .pin_change_req(pin_change_req), .other_irq_req(other_irq_req),
    .wdt_reset_req(wdt_reset_req), .ext_reset_req(ext_reset_req), .ext_irq_req(s_ext_irq_req),
    .cpu_halt(s_cpu_halt), .main_osc_stop(s_main_osc_stop), .pc_flag_hold(s_pc_flag_hold),
    .restart_reset_vector(s_restart), .osc_trim(s_osc_trim));

  swk_pin_model drv (.pclk(pclk), .presetn(presetn), .want_low(want_low),
    .level_mode(level_mode), .instr_done(instr_done), .ext_irq_pin(ext_irq_pin));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic pulse_sleep();
    sleep_exec <= 1'b1;
    cyc(1);
    sleep_exec <= 1'b0;
    cyc(2);
  endtask

  // power-down wake by low level or pin change, optionally lost at cycle drop
  task automatic pd_run(input logic [1:0] f, input logic by_pin, input int drop, input int lo,
                        input int hi, input logic [31:0] stat);
    int n;
    clock_source_fuses <= f;
    level_mode         <= by_pin;
    wr(swk_pkg::OFS_MCU_CONTROL, by_pin ? 32'h30 : 32'h32);
    pulse_sleep();
    chk(main_osc_stop, 1'b1);
    if (!by_pin)
    begin
      want_low <= 1'b1;
      cyc(3);
      want_low <= 1'b0;
      cyc(10);
      rd(swk_pkg::OFS_SLEEP_STAT, 32'h04);
    end
    // the wake source is held until cpu_halt falls, unless dropped at cycle drop
    if (by_pin) want_low <= 1'b1; else pin_change_req <= 1'b1;
    n = 0;
    while (cpu_halt === 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
      if (n == drop) pin_change_req <= 1'b0;
      #1;
    end
    @(posedge pclk);
    want_low       <= 1'b0;
    pin_change_req <= 1'b0;
    chk(32'(n >= lo && n <= hi), 32'h1);
    chk(main_osc_stop, 1'b0);
    chk(pc_flag_hold, 1'b0);
    rd(swk_pkg::OFS_SLEEP_STAT, stat);
    rd(swk_pkg::OFS_MCU_CONTROL, by_pin ? 32'h30 : 32'h32);
    chk(osc_trim, 8'ha5);
    wr(swk_pkg::OFS_IRQ_FLAG, 32'h40);
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence; the whole run needs about 900 cycles
  // ---------------------------------------------------------------
  initial
  begin
    #500000;
    errors++;
    test_done();
  end

  initial
  begin
    cyc(12);
    presetn <= 1'b1;
    rd(swk_pkg::OFS_MCU_CONTROL, 32'(swk_pkg::MCU_CONTROL_RST));
    rd(swk_pkg::OFS_IRQ_MASK, 32'h0);
    rd(swk_pkg::OFS_SLEEP_STAT, 32'h01);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'hff);
    rd(swk_pkg::OFS_MCU_CONTROL, 32'(swk_pkg::MCU_CONTROL_WM));
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(pready, 32'h1);
    chk(rdata, 32'h0);
    rd(swk_pkg::OFS_OSC_TRIM, 32'(swk_pkg::OSC_TRIM_RST));
    wr(swk_pkg::OFS_OSC_TRIM, 32'ha5);
    rd(swk_pkg::OFS_OSC_TRIM, 32'ha5);
    wr(swk_pkg::OFS_IRQ_MASK, 32'h40);
    status_word_gie <= 1'b1;
    for (int c = 1; c < 4; c++)
    begin
      wr(swk_pkg::OFS_MCU_CONTROL, 32'(c));
      wr(swk_pkg::OFS_IRQ_FLAG, 32'h40);
      want_low <= 1'b1;
      cyc(6);
      chk(ext_irq_req, 32'(c != 3));
      rd(swk_pkg::OFS_IRQ_FLAG, (c != 3) ? 32'h40 : 32'h0);
      wr(swk_pkg::OFS_IRQ_FLAG, 32'h40);
      want_low <= 1'b0;
      cyc(6);
      chk(ext_irq_req, 32'(c != 2));
      rd(swk_pkg::OFS_IRQ_FLAG, (c != 2) ? 32'h40 : 32'h0);
    end
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h02);
    wr(swk_pkg::OFS_IRQ_FLAG, 32'h40);
    status_word_gie <= 1'b0;
    want_low        <= 1'b1;
    cyc(6);
    chk(ext_irq_req, 32'h0);
    rd(swk_pkg::OFS_IRQ_FLAG, 32'h40);
    status_word_gie <= 1'b1;
    cyc(2);
    chk(ext_irq_req, 32'h1);
    ext_irq_ack <= 1'b1;
    cyc(1);
    ext_irq_ack <= 1'b0;
    cyc(2);
    rd(swk_pkg::OFS_IRQ_FLAG, 32'h0);
    want_low <= 1'b0;
    cyc(6);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h00);
    level_mode <= 1'b1;
    want_low   <= 1'b1;
    cyc(6);
    chk(ext_irq_req, 32'h1);
    cyc(30);
    chk(ext_irq_req, 32'h1);
    rd(swk_pkg::OFS_IRQ_FLAG, 32'h0);
    want_low <= 1'b0;
    cyc(8);
    chk(ext_irq_req, 32'h0);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h10);
    pulse_sleep();
    chk(cpu_halt, 32'h0);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h20);
    pulse_sleep();
    chk(cpu_halt, 32'h1);
    chk(main_osc_stop, 32'h0);
    rd(swk_pkg::OFS_SLEEP_STAT, 32'h02);
    other_irq_req <= 1'b1;
    nl = 0;
    ns = 0;
    repeat (12)
    begin
      @(posedge pclk);
      #1;
      nl += int'(cpu_halt);
      ns += int'(s_cpu_halt);
    end
    @(posedge pclk);
    other_irq_req <= 1'b0;
    chk(nl, 32'd4);
    chk(ns, 32'd0);
    rd(swk_pkg::OFS_MCU_CONTROL, 32'h20);
    pd_run(2'h1, 1'b1, 0, 18, 45, 32'h01);
    pd_run(2'h1, 1'b0, 0, 18, 45, 32'h01);
    chk(idc, 32'd2);
    pd_run(2'h3, 1'b0, 40, 430, 480, 32'h81);
    pd_run(2'h0, 1'b0, 0, 5, 15, 32'h01);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h20);
    pulse_sleep();
    ext_reset_req <= 1'b1;
    cyc(1);
    ext_reset_req <= 1'b0;
    cyc(4);
    chk(rv_seen, 32'h1);
    chk(cpu_halt, 32'h0);
    wr(swk_pkg::OFS_MCU_CONTROL, 32'h30);
    pulse_sleep();
    chk(main_osc_stop, 32'h1);
    wdt_reset_req <= 1'b1;
    cyc(1);
    wdt_reset_req <= 1'b0;
    #1;
    chk(restart_reset_vector, 32'h1);
    cyc(1);
    chk(main_osc_stop, 32'h0);
    test_done();
  end
endmodule
